// File: rsscp_pkg.sv
// Purpose: Shared constants for the reset sources and startup counter.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package rsscp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_SERVICE = 8'h18;
  // ----------------------------------------------------------------
  // Cause and event bit positions
  // ----------------------------------------------------------------
  localparam int CAUSE_W = 6;
  localparam int B_POWERUP = 0;
  localparam int B_PIN = 1;
  localparam int B_WDOG = 2;
  localparam int B_BAD_OP = 3;
  localparam int B_BAD_FETCH = 4;
  localparam int B_UNDERV = 5;
  // Control register bits
  localparam int B_STOP_ALLOWED = 0;
  localparam int B_SHORT_STOP_REC = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Startup counter
  // ----------------------------------------------------------------
  localparam int SC_STAGES = 12;
  localparam int SVC_CLR_LO = 4;
  localparam int SVC_CLR_HI = 11;
  localparam logic [11:0] RELEASE_CYC = 12'h040;
  localparam logic [11:0] SHORT_REC_CYC = 12'h020;
  // ----------------------------------------------------------------
  // Core opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STOP = 8'h8E;
  localparam logic [7:0] OP_HOLE_0 = 8'h32;
  localparam logic [7:0] OP_HOLE_1 = 8'h3E;
  localparam logic [7:0] OP_HOLE_2 = 8'h82;
  localparam logic [7:0] OP_HOLE_3 = 8'h8D;
  localparam logic [7:0] OP_HOLE_4 = 8'h96;
  localparam logic [7:0] OP_HOLE_5 = 8'hAC;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_POWERUP = 6'h01,
    ST_HOLD = 6'h02,
    ST_RELEASE = 6'h04,
    ST_RUN = 6'h08,
    ST_STOPPED = 6'h10,
    ST_RECOVER = 6'h20
  } rsscp_state_t;
endpackage

// File: rsscp_top.sv
// Purpose: Internal reset sources, reset pin driver and startup counter.
// Assumes: All inputs synchronous to clk_sys; clk_sys is the internal
//          timebase clock.
// Notes:   The startup counter runs on the falling edge of clk_sys.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// What this block does
// - Watchdog overflow resets the chip and records the watchdog cause.
// - Every internal reset source drives the reset pin low.
// - Any service write clears watchdog and startup stages 12 to 5.
// - Startup counter ticks the watchdog at most every 4096-16 cycles.
// - Watchdog disabled only by qualified test high voltage on pins.
// - Illegal opcodes set the bad opcode cause and reset the chip.
// - Stop with stop not allowed counts as an illegal opcode.
// - Opcode fetch from unmapped space sets bad fetch cause and resets.
// - Data reads from unmapped space cause nothing.
// - Undervoltage: pin low 4096 cycles, core freed 64 cycles later.
// - Twelve counting stages plus a thirteenth that wraps and ticks.
// - Startup counter advances on the falling clock edge.
// - Bus clocks wait for the startup counter after power-up and stop.
// - Power-up signal initialises startup logic, then enables oscillator.
// - Executing stop clears the startup counter.
// - Stop wake waits 32 cycles if short recovery, else 4096.
// - External reset pin alone leaves the startup counter alone.
// - Startup counter runs freely after every reset state.
module rsscp_top #(
  parameter int WDOG_W = 6
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_op_valid,
  input wire logic [7:0] core_opcode,
  input wire logic core_opcode_fetch,
  input wire logic core_addr_unmapped,
  input wire logic core_wake,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic test_high_voltage_rst,
  input wire logic test_high_voltage_irq,
  input wire logic undervoltage,
  input wire logic powerup_reset_signal,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic core_reset_n,
  output logic internal_bus_clocks_en,
  output logic osc_enable,
  output logic irq
);
  // Refused at elaboration: the watchdog needs at least one stage
  if (WDOG_W < 1 || WDOG_W > 16)
  begin
    $error("WDOG_W must lie in 1..16");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = rsscp_pkg::CAUSE_W;
  rsscp_pkg::rsscp_state_t st_q, st_d;
  logic [rsscp_pkg::SC_STAGES-1:0] sc_q;
  logic sc_tick_q;
  logic sc_clr_q, sc_clr_d;
  logic svc_q;
  logic [WDOG_W-1:0] wd_q;
  logic [CW-1:0] cause_q, cause_d;
  logic [CW-1:0] irq_stat_q, irq_en_q;
  logic [1:0] ctrl_q;
  logic pin_prev_q;
  logic [31:0] rdata_d;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic op_is_hole(input logic [7:0] op);
    op_is_hole = (op == rsscp_pkg::OP_HOLE_0) ||
                 (op == rsscp_pkg::OP_HOLE_1) ||
                 (op == rsscp_pkg::OP_HOLE_2) ||
                 (op == rsscp_pkg::OP_HOLE_3) ||
                 (op == rsscp_pkg::OP_HOLE_4) ||
                 (op == rsscp_pkg::OP_HOLE_5);
  endfunction

  function automatic logic in_state(input rsscp_pkg::rsscp_state_t a,
                                    input rsscp_pkg::rsscp_state_t b);
    in_state = (a == b);
  endfunction

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_cause = paddr == rsscp_pkg::OFF_CAUSE;
  wire hit_stat = paddr == rsscp_pkg::OFF_IRQ_STAT;
  wire hit_clr = paddr == rsscp_pkg::OFF_IRQ_CLR;
  wire hit_en = paddr == rsscp_pkg::OFF_IRQ_EN;
  wire hit_ctrl = paddr == rsscp_pkg::OFF_CTRL;
  wire hit_state = paddr == rsscp_pkg::OFF_STATE;
  wire hit_svc = paddr == rsscp_pkg::OFF_SERVICE;
  wire mapped = hit_cause | hit_stat | hit_clr | hit_en | hit_ctrl |
                hit_state | hit_svc;
  wire svc_wr = wr && hit_svc;

  wire stop_allowed = ctrl_q[rsscp_pkg::B_STOP_ALLOWED];
  wire short_rec = ctrl_q[rsscp_pkg::B_SHORT_STOP_REC];
  wire running = in_state(st_q, rsscp_pkg::ST_RUN);
  wire is_stop = core_op_valid && core_opcode == rsscp_pkg::OP_STOP;
  // Stop is illegal unless the option allows it
  wire bad_op = running && core_op_valid &&
                (op_is_hole(core_opcode) ||
                 (is_stop && !stop_allowed));
  // Only opcode fetches count; data reads from holes are ignored
  wire bad_fetch = running && core_opcode_fetch &&
                   core_addr_unmapped;
  wire go_stop = running && is_stop && stop_allowed;
  // Purely combinational so noise cannot latch the watchdog off
  wire wd_disable = (monitor_mode &&
                     (test_high_voltage_rst || test_high_voltage_irq)) ||
                    (break_state && test_high_voltage_rst);
  wire wd_timeout = !wd_disable && sc_tick_q && (&wd_q);
  wire wd_event = running && wd_timeout;
  wire uv_event = undervoltage &&
                  !in_state(st_q, rsscp_pkg::ST_POWERUP) &&
                  !in_state(st_q, rsscp_pkg::ST_HOLD);
  wire pin_event = pin_prev_q && !rst_pin_i && !rst_pin_oe;
  wire int_reset = uv_event || wd_event || bad_op || bad_fetch;
  // The counter is cleared half a cycle after a wait starts, so each wait
  // ends on the count just before its target, not on the count itself
  wire sc_last = &sc_q;
  wire [rsscp_pkg::SC_STAGES-1:0] sc_next = sc_q + 1'b1;

  // ----------------------------------------------------------------
  // Startup counter (falling edge)
  // ----------------------------------------------------------------
  // Twelve stages wrap into a thirteenth that ticks the watchdog. A
  // service write clears only the upper stages, so the next tick is at
  // least 4096-16 cycles away. The reset pin is not an input here.
  always_ff @(negedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sc_q <= '0;
      sc_tick_q <= 1'b0;
    end
    else if (powerup_reset_signal || sc_clr_q)
    begin
      sc_q <= '0;
      sc_tick_q <= 1'b0;
    end
    else if (svc_q)
    begin
      sc_q[rsscp_pkg::SVC_CLR_HI:rsscp_pkg::SVC_CLR_LO] <= '0;
      sc_tick_q <= 1'b0;
    end
    else
    begin
      sc_q <= sc_q + 1'b1;
      sc_tick_q <= &sc_q;
    end
  end

  // ----------------------------------------------------------------
  // Reset and recovery sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    sc_clr_d = 1'b0;
    case (st_q)
      rsscp_pkg::ST_POWERUP:
        if (!powerup_reset_signal)
        begin
          st_d = rsscp_pkg::ST_HOLD;
          sc_clr_d = 1'b1;
        end
      rsscp_pkg::ST_HOLD:
        if (sc_last)
          st_d = rsscp_pkg::ST_RELEASE;
      rsscp_pkg::ST_RELEASE:
        if (sc_next == rsscp_pkg::RELEASE_CYC)
          st_d = rsscp_pkg::ST_RUN;
      rsscp_pkg::ST_RUN:
        if (int_reset)
        begin
          st_d = rsscp_pkg::ST_HOLD;
          sc_clr_d = 1'b1;
        end
        else if (go_stop)
        begin
          st_d = rsscp_pkg::ST_STOPPED;
          sc_clr_d = 1'b1;
        end
      rsscp_pkg::ST_STOPPED:
      begin
        sc_clr_d = 1'b1;
        if (core_wake || !rst_pin_i)
          st_d = rsscp_pkg::ST_RECOVER;
      end
      rsscp_pkg::ST_RECOVER:
        if (short_rec ? (sc_next == rsscp_pkg::SHORT_REC_CYC) : sc_last)
          st_d = rsscp_pkg::ST_RUN;
      default:
        st_d = rsscp_pkg::ST_POWERUP;
    endcase
    if (powerup_reset_signal)
      st_d = rsscp_pkg::ST_POWERUP;
    else if (uv_event)
    begin
      st_d = rsscp_pkg::ST_HOLD;
      sc_clr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= rsscp_pkg::ST_POWERUP;
      sc_clr_q <= 1'b0;
      svc_q <= 1'b0;
      pin_prev_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      sc_clr_q <= sc_clr_d;
      svc_q <= svc_wr;
      pin_prev_q <= rst_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Liveness watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wd_q <= '0;
    else if (wd_disable || svc_wr || !running)
      wd_q <= '0;
    else if (sc_tick_q)
      wd_q <= wd_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  // A new reset replaces the old causes; simultaneous causes all show, but power-up shows alone.
  always_comb
  begin
    cause_d = cause_q;
    if (powerup_reset_signal)
    begin
      cause_d = '0;
      cause_d[rsscp_pkg::B_POWERUP] = 1'b1;
    end
    else if (int_reset || pin_event)
    begin
      cause_d = '0;
      cause_d[rsscp_pkg::B_UNDERV] = uv_event;
      cause_d[rsscp_pkg::B_WDOG] = wd_event;
      cause_d[rsscp_pkg::B_BAD_OP] = bad_op;
      cause_d[rsscp_pkg::B_BAD_FETCH] = bad_fetch;
      cause_d[rsscp_pkg::B_PIN] = pin_event;
    end
  end

  wire [CW-1:0] clr_bits = (wr && hit_clr) ? pwdata[CW-1:0] : '0;
  // A repeated cause is still a new event for the sticky status bits
  wire new_reset = (int_reset || pin_event) && !powerup_reset_signal;
  wire [CW-1:0] ev_bits = new_reset ? cause_d : (cause_d & ~cause_q);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cause_q <= '0;
      irq_stat_q <= '0;
      irq_en_q <= '0;
      ctrl_q <= rsscp_pkg::CTRL_RESET;
    end
    else
    begin
      cause_q <= cause_d;
      // A new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~clr_bits) | ev_bits;
      if (wr && hit_en)
        irq_en_q <= pwdata[CW-1:0];
      if (wr && hit_ctrl)
        ctrl_q <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // APB read path and outputs
  // ----------------------------------------------------------------
  assign rdata_d = hit_cause ? {{(32-CW){1'b0}}, cause_q} :
                   hit_stat ? {{(32-CW){1'b0}}, irq_stat_q} :
                   hit_en ? {{(32-CW){1'b0}}, irq_en_q} :
                   hit_ctrl ? {30'h0, ctrl_q} :
                   hit_state ? {14'h0, st_q, sc_q} :
                   32'h0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign irq = |(irq_stat_q & irq_en_q);
  // Internal sources pull the pin low for the whole hold period
  assign rst_pin_oe = in_state(st_q, rsscp_pkg::ST_HOLD);
  assign rst_pin_o = 1'b0;
  // Stop and its recovery leave the core out of reset; only reset states
  // and the pin hold it
  assign core_reset_n = rst_pin_i &&
                        !in_state(st_q, rsscp_pkg::ST_POWERUP) &&
                        !in_state(st_q, rsscp_pkg::ST_HOLD) &&
                        !in_state(st_q, rsscp_pkg::ST_RELEASE);
  assign internal_bus_clocks_en = running;
  assign osc_enable = !in_state(st_q, rsscp_pkg::ST_POWERUP);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wdog_cause_set: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    wd_event && !powerup_reset_signal |=>
      cause_q[rsscp_pkg::B_WDOG] && st_q == rsscp_pkg::ST_HOLD)
    else $error("watchdog overflow did not reset");

  a_pin_driven_low: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    int_reset && !powerup_reset_signal |=> rst_pin_oe && !rst_pin_o)
    else $error("reset pin not driven on internal reset");

  a_service_clears_wd: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    svc_wr |=> wd_q == '0 ##0
      sc_q[rsscp_pkg::SVC_CLR_HI:rsscp_pkg::SVC_CLR_LO] == '0)
    else $error("service write did not clear counters");

  a_wdog_disabled: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    monitor_mode && test_high_voltage_irq |=> wd_q == '0)
    else $error("watchdog ran while disabled");

  a_stop_illegal: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    running && is_stop && !stop_allowed && !powerup_reset_signal |=>
      cause_q[rsscp_pkg::B_BAD_OP] && core_reset_n == 1'b0)
    else $error("forbidden stop did not reset");

  a_data_read_quiet: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    running && core_addr_unmapped && !core_opcode_fetch &&
      !core_op_valid && !undervoltage && !wd_timeout && !powerup_reset_signal
      |=> $stable(cause_q) && running)
    else $error("data read from hole caused a reset");

  a_hold_then_release: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    st_q == rsscp_pkg::ST_HOLD && sc_last && !powerup_reset_signal &&
      !undervoltage |=> st_q == rsscp_pkg::ST_RELEASE && !rst_pin_oe &&
      !core_reset_n)
    else $error("hold did not end on counter wrap");

  a_short_recovery: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    st_q == rsscp_pkg::ST_RECOVER && short_rec &&
      sc_next == rsscp_pkg::SHORT_REC_CYC && !powerup_reset_signal &&
      !undervoltage |=> internal_bus_clocks_en)
    else $error("short stop recovery missed");
endmodule

// File: rsscp_core_model.sv
// Purpose: Processor core and reset pin seen from the reset logic.
// Assumes: Core issues nothing while held in reset.
// Notes:   Reset pin has a pull-up; the board button pulls it low.
`timescale 1ns/1ps
module rsscp_core_model (
  input wire logic clk_sys,
  input wire logic core_reset_n,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic ext_rst_low,
  output logic core_op_valid,
  output logic [7:0] core_opcode,
  output logic core_opcode_fetch,
  output logic core_addr_unmapped,
  output logic core_wake,
  output logic rst_pin_i
);
  // Wired-AND of the device driver, the button and the pull-up
  assign rst_pin_i = (rst_pin_oe ? rst_pin_o : 1'b1) & ~ext_rst_low;
  initial
  begin
    core_op_valid = 1'b0;
    core_opcode = 8'h00;
    core_opcode_fetch = 1'b0;
    core_addr_unmapped = 1'b0;
    core_wake = 1'b0;
  end
  // One bus cycle; idle opcode lines show the inverse, not a stale value
  task automatic cycle(input logic [7:0] op, input logic v, input logic f,
                       input logic u);
    int k;
    k = 0;
    while (core_reset_n !== 1'b1 && k < 10000)
    begin
      @(posedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    core_op_valid <= v;
    core_opcode <= op;
    core_opcode_fetch <= f;
    core_addr_unmapped <= u;
    @(posedge clk_sys);
    core_op_valid <= 1'b0;
    core_opcode <= ~op;
    core_opcode_fetch <= 1'b0;
    core_addr_unmapped <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clk_sys);
    core_wake <= 1'b1;
    @(posedge clk_sys);
    core_wake <= 1'b0;
  endtask
endmodule

// File: test_reset_sources_startup_counter.sv
// Purpose: Self-checking bench for the reset sources and startup counter.
// Assumes: Watchdog shortened to one bit, so it overflows on the 2nd tick.
// Notes:   Every internal reset is timed on the pin and core release.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module test_reset_sources_startup_counter;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, core_opcode;
  logic [31:0] pwdata, prdata, rd;
  logic core_op_valid, core_opcode_fetch, core_addr_unmapped, core_wake;
  logic monitor_mode, break_state, tv_rst, tv_irq, undervoltage, por;
  logic rst_pin_i, rst_pin_o, rst_pin_oe, core_reset_n, bus_en, osc_en;
  logic irq, ext_low;
  logic [11:0] c1;
  logic [7:0] ops [7];
  int mismatches = 0, n_tests = 0, cyc = 0, rd_cyc, t0, oe_cyc, n;
  rsscp_top #(.WDOG_W(1)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_op_valid(core_op_valid), .core_opcode(core_opcode),
    .core_opcode_fetch(core_opcode_fetch),
    .core_addr_unmapped(core_addr_unmapped), .core_wake(core_wake),
    .monitor_mode(monitor_mode), .break_state(break_state),
    .test_high_voltage_rst(tv_rst), .test_high_voltage_irq(tv_irq),
    .undervoltage(undervoltage), .powerup_reset_signal(por),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .core_reset_n(core_reset_n), .internal_bus_clocks_en(bus_en),
    .osc_enable(osc_en), .irq(irq));
  rsscp_core_model core_u (.clk_sys(clk_sys), .core_reset_n(core_reset_n),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .ext_rst_low(ext_low),
    .core_op_valid(core_op_valid), .core_opcode(core_opcode),
    .core_opcode_fetch(core_opcode_fetch),
    .core_addr_unmapped(core_addr_unmapped), .core_wake(core_wake),
    .rst_pin_i(rst_pin_i));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic end_sim();
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus and sequence helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    `CHK("pready", 1'b1, pready);
    rd_cyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Times one internal reset: pin hold, core release, recorded cause
  task automatic wait_reset(input logic [5:0] cause, input int maxw);
    int k;
    k = 0;
    while (rst_pin_oe !== 1'b1 && k < maxw)
    begin
      @(posedge clk_sys);
      k++;
    end
    oe_cyc = cyc;
    `CHK("pin_drive", 1'b1, rst_pin_oe);
    `CHK("pin_level", 1'b0, rst_pin_o);
    `CHK("core_held", 1'b0, core_reset_n);
    @(posedge clk_sys);
    `CHK("bus_off", 1'b0, bus_en);
    `CHK("osc_on", 1'b1, osc_en);
    k = 1;
    while (rst_pin_oe === 1'b1 && k < 5000)
    begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("hold_len", 4096, k);
    k = 0;
    while (core_reset_n !== 1'b1 && k < 200)
    begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("release_len", 64, k);
    @(posedge clk_sys);
    `CHK("bus_on", 1'b1, bus_en);
    apb(1'b0, rsscp_pkg::OFF_CAUSE, 32'h0);
    `CHK("cause", cause, rd[5:0]);
    `CHK("cause_ok", 1'b0, err);
    apb(1'b1, rsscp_pkg::OFF_SERVICE, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {monitor_mode, break_state, tv_rst, tv_irq, undervoltage} = '0;
    ext_low = 1'b0;
    por = 1'b1;
    ops = '{rsscp_pkg::OP_HOLE_0, rsscp_pkg::OP_HOLE_1, rsscp_pkg::OP_HOLE_2,
      rsscp_pkg::OP_HOLE_3, rsscp_pkg::OP_HOLE_4, rsscp_pkg::OP_HOLE_5,
      rsscp_pkg::OP_STOP};
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK("osc_off", 1'b0, osc_en);
    por <= 1'b0;
    wait_reset(6'h01, 100);
    apb(1'b0, rsscp_pkg::OFF_CTRL, 32'h0);
    `CHK("ctrl_rst", rsscp_pkg::CTRL_RESET, rd[1:0]);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped_err", 1'b1, err);
    apb(1'b1, rsscp_pkg::OFF_IRQ_CLR, 32'h3F);
    apb(1'b1, rsscp_pkg::OFF_IRQ_EN, 32'h3F);
    @(posedge clk_sys);
    `CHK("irq_idle", 1'b0, irq);
    // Stop not allowed after reset, so it joins the illegal list
    foreach (ops[i])
    begin
      core_u.cycle(ops[i], 1'b1, 1'b0, 1'b0);
      wait_reset(6'h08, 20);
    end
    apb(1'b0, rsscp_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("irq_stat", 6'h08, rd[5:0]);
    `CHK("irq_on", 1'b1, irq);
    apb(1'b1, rsscp_pkg::OFF_IRQ_EN, 32'h0);
    @(posedge clk_sys);
    `CHK("irq_masked", 1'b0, irq);
    apb(1'b1, rsscp_pkg::OFF_IRQ_EN, 32'h3F);
    apb(1'b1, rsscp_pkg::OFF_IRQ_CLR, 32'h3F);
    @(posedge clk_sys);
    `CHK("irq_clr", 1'b0, irq);
    core_u.cycle(8'h00, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge clk_sys);
    `CHK("data_unmapped", 1'b0, rst_pin_oe);
    apb(1'b0, rsscp_pkg::OFF_CAUSE, 32'h0);
    `CHK("cause_kept", 6'h08, rd[5:0]);
    core_u.cycle(8'h00, 1'b0, 1'b1, 1'b1);
    wait_reset(6'h10, 20);
    @(posedge clk_sys);
    undervoltage <= 1'b1;
    @(posedge clk_sys);
    undervoltage <= 1'b0;
    wait_reset(6'h20, 20);
    // External pin alone: counter keeps its pace
    apb(1'b0, rsscp_pkg::OFF_STATE, 32'h0);
    c1 = rd[11:0];
    t0 = rd_cyc;
    ext_low <= 1'b1;
    repeat (20) @(posedge clk_sys);
    `CHK("pin_core", 1'b0, core_reset_n);
    ext_low <= 1'b0;
    apb(1'b0, rsscp_pkg::OFF_STATE, 32'h0);
    `CHK("pin_count", 12'(rd_cyc - t0), rd[11:0] - c1);
    `CHK("pin_state", rsscp_pkg::ST_RUN, rd[17:12]);
    // Stop with short and then full recovery
    apb(1'b1, rsscp_pkg::OFF_CTRL, 32'h3);
    core_u.cycle(rsscp_pkg::OP_STOP, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, rsscp_pkg::OFF_STATE, 32'h0);
    `CHK("stopped", rsscp_pkg::ST_STOPPED, rd[17:12]);
    `CHK("stop_clr", 12'h000, rd[11:0]);
    `CHK("stop_bus", 1'b0, bus_en);
    core_u.wake();
    n = 0;
    while (bus_en !== 1'b1 && n < 6000)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("short_rec", 1'b1, n >= 29 && n <= 35);
    apb(1'b1, rsscp_pkg::OFF_CTRL, 32'h1);
    core_u.cycle(rsscp_pkg::OP_STOP, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    ext_low <= 1'b1;
    @(posedge clk_sys);
    ext_low <= 1'b0;
    n = 0;
    while (bus_en !== 1'b1 && n < 6000)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("long_rec", 1'b1, n >= 4090 && n <= 4100);
    // Watchdog disabled only by qualified high voltage
    monitor_mode <= 1'b1;
    tv_irq <= 1'b1;
    apb(1'b1, rsscp_pkg::OFF_SERVICE, 32'h0);
    repeat (9000) @(posedge clk_sys);
    `CHK("wd_mon", 1'b0, rst_pin_oe);
    {monitor_mode, tv_irq, break_state, tv_rst} <= 4'h3;
    repeat (9000) @(posedge clk_sys);
    `CHK("wd_brk", 1'b0, rst_pin_oe);
    apb(1'b1, rsscp_pkg::OFF_SERVICE, 32'h0);
    break_state <= 1'b0;
    t0 = rd_cyc;
    apb(1'b0, rsscp_pkg::OFF_STATE, 32'h0);
    `CHK("svc_clr", 7'h00, rd[11:5]);
    wait_reset(6'h04, 9000);
    `CHK("wd_time", 1'b1, oe_cyc - t0 >= 8170 && oe_cyc - t0 <= 8200);
    end_sim();
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
endmodule
